// ---- rtl/timer5_top.sv ----
// Two 8-bit timer/event counters with port 5 direction and output latch
`timescale 1ns/1ps

// Behaviour
// - Counter is 8 bits, read-only to software
// - Counter steps once per selected count tick
// - Counter cleared by reset, stop, clear-mode match
// - Outside PWM, match raises the interrupt request
// - PWM active at overflow, inactive at match
// - Compare register full range, RW, reset zero
// - First counter clock decode: edges, 2..8192
// - Second counter decode: edges, 2..8192, osc/128
// - Mode bit 7 is count enable
// - Mode bit 6 selects clear-mode or PWM
// - Bits 3:2 set or clear output flop outside PWM
// - Bit 1 toggle enable or PWM polarity
// - Bit 0 gates the timer output
// - Set and reset bits read as zero
// - Stopping in PWM forces output inactive
// - Mode settings reach the pin at once
// - Direction zero drives pin, direction resets to ones
module timer5_top
  import timer5_pkg::*;
(
  input wire logic i_clk,              // System clock, 200 MHz
  input wire logic i_rst_n,            // Synchronous reset, active low
  input wire logic [15:0] i_addr,      // CPU memory address
  input wire logic i_wr,               // Write strobe, one cycle
  input wire logic i_rd,               // Read strobe, one cycle
  input wire logic [7:0] i_wdata,      // Write data
  output logic [7:0] o_rdata,          // Read data, valid cycle after i_rd
  input wire logic i_osc_tick,         // Internal oscillator pulse
  input wire logic [7:0] i_port_in,    // Port pin levels; bits 1:0 are event inputs
  output logic [7:0] o_port_out,       // Port pin drive values
  output logic [7:0] o_port_oe,        // Port pin output enables, high drives
  output logic [1:0] o_compare_match_irq // Compare match interrupt pulses
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] count_value;    // Counters
    logic [1:0][7:0] compare_value;  // Compare as written by software
    logic [1:0][7:0] cmp_eff;        // Compare in force (PWM reload buffer)
    logic [1:0][CSEL_W-1:0] csel;    // Clock select codes
    logic [1:0] tce;                 // Count enable bits
    logic [1:0] pwm;                 // PWM mode bits
    logic [1:0] lvl;                 // Level or toggle bits
    logic [1:0] toe;                 // Output enable bits
    logic [1:0] flop;                // Timer output flop
    logic [1:0] pwm_act;             // PWM output flop, 1 = active
    logic [1:0] pin_prev;            // Event pin level last cycle
    logic [1:0] irq;                 // Interrupt pulses
    logic [7:0] dir;                 // Port direction, 1 = input
    logic [7:0] latch;               // Port output latch
    logic [7:0] rdata;               // Read data
    logic [7:0] port_out;            // Pin drive values
    logic [7:0] port_oe;             // Pin output enables
  } state_t;

  state_t q;  // Present state
  state_t d;  // Next state

  logic [TICK_W-1:0] tick;   // Prescaler ticks
  logic [1:0] cnt_tick;      // Selected count clock per counter
  logic [1:0] tout;          // Gated timer output per counter
  logic [1:0] match;         // Counter equals compare in force

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  timer5_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_osc_tick(i_osc_tick),
    .o_tick(tick)
  );

  // ----------------------------------------------------------------
  // Per-counter count clock and output
  // ----------------------------------------------------------------
  // Both counters share one body; only the decode table and addresses differ
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    // Pin edges come straight from synchronous inputs, so no filter is needed
    always_comb begin
      case (q.csel[g])
        SEL_PIN_FALL: cnt_tick[g] = q.pin_prev[g] && !i_port_in[g];
        SEL_PIN_RISE: cnt_tick[g] = !q.pin_prev[g] && i_port_in[g];
        default: cnt_tick[g] = tick[CLK_SRC[g][q.csel[g]]];
      endcase
    end

    assign match[g] = (q.count_value[g] == q.cmp_eff[g]);

    // Mode bits drive the output directly, counting or not
    always_comb begin
      if (!q.toe[g]) begin
        tout[g] = 1'b0;
      end else if (q.pwm[g]) begin
        tout[g] = q.pwm_act[g] ^ q.lvl[g];
      end else begin
        tout[g] = q.flop[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.irq = '0;
    d.pin_prev = i_port_in[1:0];

    // Counters
    for (int i = 0; i < NUM_CH; i++) begin
      if (!q.tce[i]) begin
        // Stopped: hold at zero, PWM output inactive
        d.count_value[i] = REG_RESET;
        d.pwm_act[i] = 1'b0;
        d.cmp_eff[i] = q.compare_value[i];
      end else if (cnt_tick[i]) begin
        if (q.pwm[i]) begin
          // Free running; compare takes effect only at overflow
          d.count_value[i] = q.count_value[i] + 8'h01;
          if (q.count_value[i] == COUNT_MAX) begin
            d.cmp_eff[i] = q.compare_value[i];
            d.pwm_act[i] = (q.compare_value[i] != REG_RESET);
          end else if (q.count_value[i] + 8'h01 == q.cmp_eff[i]) begin
            d.pwm_act[i] = 1'b0;
          end
        end else if (match[i]) begin
          // Clear and start; interval is compare plus one
          d.count_value[i] = REG_RESET;
          d.irq[i] = 1'b1;
          if (q.lvl[i]) begin
            d.flop[i] = !q.flop[i];
          end
        end else begin
          d.count_value[i] = q.count_value[i] + 8'h01;
        end
      end
      // Outside PWM the compare is used as written
      if (!q.pwm[i]) begin
        d.cmp_eff[i] = d.compare_value[i];
      end
    end

    // Register writes
    if (i_wr) begin
      if (i_addr == ADDR_PORT_DIR) begin
        d.dir = i_wdata;
      end
      if (i_addr == ADDR_PORT_LATCH) begin
        d.latch = i_wdata;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (i_addr == ADDR_CSEL[i]) begin
          d.csel[i] = i_wdata[CSEL_W-1:0];
        end
        if (i_addr == ADDR_CMP[i]) begin
          d.compare_value[i] = i_wdata;
          if (!q.pwm[i]) begin
            d.cmp_eff[i] = i_wdata;
          end
        end
        if (i_addr == ADDR_MODE[i]) begin
          d.tce[i] = i_wdata[BIT_TCE];
          d.pwm[i] = i_wdata[BIT_PWM];
          d.lvl[i] = i_wdata[BIT_LVL];
          d.toe[i] = i_wdata[BIT_TOE];
          if (!i_wdata[BIT_TCE]) begin
            d.count_value[i] = REG_RESET;
            d.pwm_act[i] = 1'b0;
          end
          // Set/reset act at once and are not stored; 11 leaves the flop
          if (!i_wdata[BIT_PWM]) begin
            case ({i_wdata[BIT_LVS], i_wdata[BIT_LVR]})
              2'b01: d.flop[i] = 1'b0;
              2'b10: d.flop[i] = 1'b1;
              default: d.flop[i] = d.flop[i];
            endcase
          end
        end
        // Count value register ignores writes
      end
    end

    // Register reads
    if (i_rd) begin
      d.rdata = UNMAPPED_READ;
      if (i_addr == ADDR_PORT_DIR) begin
        d.rdata = q.dir;
      end
      if (i_addr == ADDR_PORT_LATCH) begin
        d.rdata = q.latch;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (i_addr == ADDR_CSEL[i]) begin
          d.rdata = {5'h00, q.csel[i]};
        end
        if (i_addr == ADDR_MODE[i]) begin
          // Set and reset bits always read back as zero
          d.rdata = {q.tce[i], q.pwm[i], 4'h0, q.lvl[i], q.toe[i]};
        end
        if (i_addr == ADDR_COUNT[i]) begin
          d.rdata = q.count_value[i];
        end
        if (i_addr == ADDR_CMP[i]) begin
          // Returns the written value even before a PWM reload
          d.rdata = q.compare_value[i];
        end
      end
    end

    // Pins: timer output merges with the latch, direction 0 drives
    d.port_out = q.latch;
    d.port_out[1:0] = q.latch[1:0] | tout;
    d.port_oe = ~q.dir;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.dir <= DIR_RESET;
      q.port_oe <= ~DIR_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_port_out = q.port_out;
  assign o_port_oe = q.port_oe;
  assign o_compare_match_irq = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Per-counter checks; writes are excluded where they may override the counter path
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    a_stopped_zero: assert property (!q.tce[g] |-> q.count_value[g] == 8'h00)
      else $error("counter not zero while stopped");

    a_count_step: assert property (
      q.tce[g] && cnt_tick[g] && !(match[g] && !q.pwm[g]) && !i_wr |=>
      q.count_value[g] == $past(q.count_value[g]) + 8'h01)
      else $error("counter did not step by one");

    a_count_hold: assert property (
      q.tce[g] && !cnt_tick[g] && !i_wr |=> $stable(q.count_value[g]))
      else $error("counter moved without a count tick");

    // Pin edge counting, rising code; the falling code mirrors it
    a_rise_count: assert property (
      q.tce[g] && q.csel[g] == SEL_PIN_RISE && !q.pin_prev[g] && i_port_in[g] &&
      !(match[g] && !q.pwm[g]) && !i_wr |=> q.count_value[g] == $past(q.count_value[g]) + 8'h01)
      else $error("rising pin edge not counted");

    a_stop_clears: assert property (
      i_wr && i_addr == ADDR_MODE[g] && !i_wdata[BIT_TCE] |=> q.count_value[g] == 8'h00 && !q.pwm_act[g])
      else $error("stop write did not clear the counter");

    a_compare_write: assert property (
      i_wr && i_addr == ADDR_CMP[g] |=> q.compare_value[g] == $past(i_wdata))
      else $error("compare write not stored");

    // The interrupt output is the registered pulse itself, one edge after the match tick
    a_match_irq: assert property (
      q.tce[g] && !q.pwm[g] && cnt_tick[g] && match[g] && !i_wr |=>
      o_compare_match_irq[g] && q.count_value[g] == 8'h00)
      else $error("match did not clear and interrupt");

    a_irq_only_match: assert property (
      !(q.tce[g] && !q.pwm[g] && cnt_tick[g] && match[g]) |=> !q.irq[g])
      else $error("interrupt without a compare match");

    a_pwm_no_irq: assert property (q.pwm[g] |=> !q.irq[g])
      else $error("interrupt raised in PWM mode");

    // PWM: active from overflow until the count reaches the compare in force
    a_pwm_rise: assert property (
      q.tce[g] && q.pwm[g] && cnt_tick[g] && q.count_value[g] == 8'hFF &&
      q.compare_value[g] != 8'h00 && !i_wr |=> q.pwm_act[g])
      else $error("PWM not active after overflow");

    a_pwm_fall: assert property (
      q.tce[g] && q.pwm[g] && cnt_tick[g] && q.count_value[g] != 8'hFF &&
      q.count_value[g] + 8'h01 == q.cmp_eff[g] && !i_wr |=> !q.pwm_act[g])
      else $error("PWM not inactive at compare");

    a_pwm_stop: assert property (q.pwm[g] && !q.tce[g] |-> !q.pwm_act[g])
      else $error("PWM active while stopped");

    // Set and clear act only through a mode write outside PWM
    a_flop_set: assert property (
      i_wr && i_addr == ADDR_MODE[g] && !i_wdata[BIT_PWM] &&
      i_wdata[BIT_LVS] && !i_wdata[BIT_LVR] |=> q.flop[g])
      else $error("flop not set by mode write");

    a_flop_clear: assert property (
      i_wr && i_addr == ADDR_MODE[g] && !i_wdata[BIT_PWM] &&
      !i_wdata[BIT_LVS] && i_wdata[BIT_LVR] |=> !q.flop[g])
      else $error("flop not cleared by mode write");

    a_match_toggle: assert property (
      q.tce[g] && !q.pwm[g] && cnt_tick[g] && match[g] && q.lvl[g] && !i_wr |=>
      q.flop[g] != $past(q.flop[g]))
      else $error("output flop did not toggle on match");

    a_gate_low: assert property (
      !q.toe[g] |=> o_port_out[g] == $past(q.latch[g]))
      else $error("disabled timer output reached pin");

    a_flop_output: assert property (
      q.toe[g] && !q.pwm[g] |=> o_port_out[g] == ($past(q.latch[g]) | $past(q.flop[g])))
      else $error("flop level not on the pin");
  end

  a_mode_read: assert property (
    i_rd && (i_addr == ADDR_MODE[0] || i_addr == ADDR_MODE[1]) |=>
    o_rdata[3:2] == 2'b00)
    else $error("set/reset bits read nonzero");

  a_dir_oe: assert property (##1 o_port_oe == ~$past(q.dir))
    else $error("pin enable does not follow direction");

endmodule

// ---- rtl/timer5_pkg.sv ----
// Shared constants and clock decode tables for the dual 8-bit timer/event counter
package timer5_pkg;

  // ----------------------------------------------------------------
  // Register map (CPU memory addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_DIR = 16'hFF25;   // Port direction register
  localparam logic [15:0] ADDR_PORT_LATCH = 16'hFF05; // Port output latch
  // Index 0 is the first counter, index 1 the second
  localparam logic [1:0][15:0] ADDR_CSEL = {16'hFF3E, 16'hFF2E};  // Clock select
  localparam logic [1:0][15:0] ADDR_MODE = {16'hFF3F, 16'hFF2F};  // Mode control
  localparam logic [1:0][15:0] ADDR_COUNT = {16'hFF3C, 16'hFF2C}; // Count value
  localparam logic [1:0][15:0] ADDR_CMP = {16'hFF3D, 16'hFF2D};   // Compare value

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hFF;  // All pins input after reset
  localparam logic [7:0] REG_RESET = 8'h00;  // Other registers clear
  localparam logic [7:0] COUNT_MAX = 8'hFF;  // Last count before overflow
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Mode control field positions
  // ----------------------------------------------------------------
  localparam int BIT_TCE = 7;  // Count enable
  localparam int BIT_PWM = 6;  // PWM mode select
  localparam int BIT_LVS = 3;  // Flop set
  localparam int BIT_LVR = 2;  // Flop reset
  localparam int BIT_LVL = 1;  // Level or toggle
  localparam int BIT_TOE = 0;  // Output enable
  localparam int CSEL_W = 3;   // Used width of clock select

  // ----------------------------------------------------------------
  // Count clock sources
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;     // Counters in the block
  localparam int DIV_W = 13;     // System clock divider, up to 2^13
  localparam int OSC_DIV_W = 7;  // Internal oscillator divider, 2^7
  localparam int TICK_W = 15;    // Tick k = system clock / 2^k, 14 = osc/128
  localparam logic [2:0] SEL_PIN_FALL = 3'h0;
  localparam logic [2:0] SEL_PIN_RISE = 3'h1;
  // Clock select code to tick index, per counter
  localparam logic [1:0][7:0][3:0] CLK_SRC = {
    {4'hE, 4'hD, 4'hA, 4'h7, 4'h5, 4'h1, 4'h0, 4'h0},
    {4'hD, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0}
  };

endpackage

// ---- rtl/timer5_prescaler.sv ----
// Free-running prescaler giving count-clock ticks to both counters
`timescale 1ns/1ps
module timer5_prescaler
  import timer5_pkg::*;
(
  input wire logic i_clk,                // System clock
  input wire logic i_rst_n,              // Synchronous reset, active low
  input wire logic i_osc_tick,           // One pulse per internal oscillator cycle
  output logic [TICK_W-1:0] o_tick       // One-cycle tick pulses
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div;      // System clock divider
    logic [OSC_DIV_W-1:0] osc;  // Oscillator divider
    logic [TICK_W-1:0] tick;    // Registered ticks
  } pre_t;

  pre_t q;  // Present state
  pre_t d;  // Next state

  // Ticks 1 to 13 fire when the low k bits of the divider are all ones
  always_comb begin
    d = q;
    d.div = q.div + DIV_W'(1);
    d.tick = '0;
    for (int k = 1; k <= DIV_W; k++) begin
      d.tick[k] = &(q.div | ~DIV_W'((1 << k) - 1));
    end
    if (i_osc_tick) begin
      d.osc = q.osc + OSC_DIV_W'(1);
    end
    d.tick[TICK_W-1] = i_osc_tick && (&q.osc);
  end

  // Register the whole state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule

// ---- verification/timer5_pin_model.sv ----
// Far-side model: event sources on the timer pins and resolved pin levels
`timescale 1ns/1ps
module timer5_pin_model (
  input wire logic i_clk,            // System clock
  input wire logic [1:0] i_pulse,    // Request one event pulse per pin
  input wire logic [7:0] i_port_out, // Device drive values
  input wire logic [7:0] i_port_oe,  // Device drive enables
  output logic [7:0] o_port_in       // Resolved pin levels
);
  logic [1:0][4:0] left_q = '0;      // Cycles left in each pulse
  logic [7:0] src;                   // Far-side level per pin
  // ----------------------------------------------------------------
  // Pulse shaping
  // ----------------------------------------------------------------
  // High for 8 cycles then low for 8, so both edges are seen apart
  always @(posedge i_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (i_pulse[k]) begin
        left_q[k] <= 5'h10;
      end else if (left_q[k] != 5'h0) begin
        left_q[k] <= left_q[k] - 5'h1;
      end
    end
  end
  // Event pins idle low behind a pull-down, the rest are pulled up
  always_comb begin
    src = 8'hFC;
    for (int k = 0; k < 2; k++) begin
      src[k] = (left_q[k] > 5'h8);
    end
  end
  // The device owns a pin only where its direction bit is clear
  assign o_port_in = (i_port_oe & i_port_out) | (~i_port_oe & src);
endmodule

// ---- verification/dual_8bit_timer_event_counter_tb.sv ----
// Self-checking bench for the dual 8-bit timer/event counter
`timescale 1ns/1ps
module dual_8bit_timer_event_counter_tb;
  import timer5_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_osc_tick = 1'b0;
  logic [15:0] i_addr = 16'h0000, cyc;
  logic [7:0] i_wdata = 8'h00, i_port_in, o_rdata, o_port_out, o_port_oe, rd, n;
  logic [1:0] o_compare_match_irq, pulse = 2'h0, osc_q = 2'h0;
  logic s0;
  int error_cnt = 0, checks_done = 0, seed = 32'hB7A83735, hi;
  // ----------------------------------------------------------------
  // Clock, oscillator pulse every 4 cycles, design and far side
  // ----------------------------------------------------------------
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    osc_q <= osc_q + 2'h1;
    i_osc_tick <= (osc_q == 2'h3);
  end
  timer5_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_osc_tick(i_osc_tick), .i_port_in(i_port_in),
    .o_port_out(o_port_out), .o_port_oe(o_port_oe), .o_compare_match_irq(o_compare_match_irq));
  timer5_pin_model pins (.i_clk(i_clk), .i_pulse(pulse), .i_port_out(o_port_out),
    .i_port_oe(o_port_oe), .o_port_in(i_port_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One-cycle strobes; the next access waits for a fresh edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // Cycles until the next interrupt pulse, bounded
  task automatic wait_irq(input int ch);
    cyc = 16'h0;
    do begin
      @(posedge i_clk);
      #1;
      cyc++;
    end while (o_compare_match_irq[ch] !== 1'b1 && cyc < 16'd20000);
    chk("irq seen", 16'(o_compare_match_irq[ch]), 16'h0001);
  endtask
  // Expected count-clock divisor; osc/128 at one osc pulse per 4 cycles
  function automatic int div_of(input int ch, input int code);
    int t0[8] = '{1, 1, 2, 4, 16, 64, 256, 8192};
    int t1[8] = '{1, 1, 2, 32, 128, 1024, 8192, 512};
    return ch ? t1[code] : t0[code];
  endfunction
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    static logic [15:0] ra[10] = '{ADDR_PORT_DIR, ADDR_CSEL[0], ADDR_MODE[0], ADDR_COUNT[0], ADDR_CMP[0],
      ADDR_CSEL[1], ADDR_MODE[1], ADDR_COUNT[1], ADDR_CMP[1], 16'hFE00};
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values, unmapped place last
    for (int i = 0; i < 10; i++) begin
      rdr(ra[i]);
      chk("reset value", 16'(rd), (i == 0) ? 16'h00FF : 16'h0000);
    end
    for (int ch = 0; ch < 2; ch++) begin
      n = 8'($random(seed));
      wr(ADDR_CMP[ch], n);
      rdr(ADDR_CMP[ch]);
      chk("compare rw", 16'(rd), 16'(n));
      wr(ADDR_COUNT[ch], 8'h5A);
      rdr(ADDR_COUNT[ch]);
      chk("count read only", 16'(rd), 16'h0000);
      wr(ADDR_MODE[ch], 8'h0A);
      rdr(ADDR_MODE[ch]);
      chk("mode readback", 16'(rd), 16'h0002);
      wr(ADDR_MODE[ch], 8'h00);
      wr(ADDR_CSEL[ch], 8'h05);
      rdr(ADDR_CSEL[ch]);
      chk("clock select rw", 16'(rd), 16'h0005);
    end
    $display("register test done");
    // Edge counting: rising code counts mid-pulse, falling only after
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 0; code < 2; code++) begin
        wr(ADDR_MODE[ch], 8'h00);
        wr(ADDR_CSEL[ch], 8'(code));
        wr(ADDR_CMP[ch], 8'hFF);
        wr(ADDR_MODE[ch], 8'h80);
        wait_clk(2);
        pulse[ch] <= 1'b1;
        @(posedge i_clk);
        pulse[ch] <= 1'b0;
        wait_clk(3);
        rdr(ADDR_COUNT[ch]);
        chk("count at rise", 16'(rd), 16'(code));
        wait_clk(16);
        rdr(ADDR_COUNT[ch]);
        chk("count after pulse", 16'(rd), 16'h0001);
        wr(ADDR_MODE[ch], 8'h00);
        rdr(ADDR_COUNT[ch]);
        chk("count on stop", 16'(rd), 16'h0000);
      end
    end
    $display("event test done");
    // Interval period per prescaler code
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 2; code < 8; code++) begin
        n = (code == 2) ? (8'($random(seed)) & 8'h0F) : 8'h00;
        wr(ADDR_MODE[ch], 8'h00);
        wr(ADDR_CSEL[ch], 8'(code));
        wr(ADDR_CMP[ch], n);
        wr(ADDR_MODE[ch], 8'h80);
        wait_irq(ch);
        wait_irq(ch);
        chk("irq period", cyc, 16'((n + 1) * div_of(ch, code)));
      end
      wr(ADDR_MODE[ch], 8'h00);
    end
    $display("interval test done");
    // Timer output, square wave and PWM on the pins
    wr(ADDR_PORT_DIR, 8'hFC);
    // Latch reads back and shows on the pins that are not timer outputs
    n = 8'($random(seed));
    wr(ADDR_PORT_LATCH, n);
    rdr(ADDR_PORT_LATCH);
    chk("port latch rw", 16'(rd), 16'(n));
    wait_clk(1);
    chk("latch on pins", 16'(o_port_out[7:2]), 16'(n[7:2]));
    wr(ADDR_PORT_LATCH, 8'h00);
    wait_clk(3);
    chk("pin enable", 16'(o_port_oe), 16'h0003);
    for (int ch = 0; ch < 2; ch++) begin
      wr(ADDR_MODE[ch], 8'h08);
      wait_clk(3);
      chk("gated output", 16'(o_port_out[ch]), 16'h0000);
      wr(ADDR_MODE[ch], 8'h09);
      wait_clk(3);
      chk("flop set", 16'(o_port_out[ch]), 16'h0001);
      wr(ADDR_MODE[ch], 8'h05);
      wait_clk(3);
      chk("flop reset", 16'(o_port_out[ch]), 16'h0000);
      wr(ADDR_MODE[ch], 8'h03);
      wr(ADDR_CSEL[ch], 8'h02);
      wr(ADDR_CMP[ch], 8'h04 + (8'($random(seed)) & 8'h07));
      wr(ADDR_MODE[ch], 8'h83);
      wait_irq(ch);
      s0 = o_port_out[ch];
      wait_irq(ch);
      chk("toggle", 16'(o_port_out[ch]), 16'(!s0));
      wait_irq(ch);
      chk("toggle back", 16'(o_port_out[ch]), 16'(s0));
      wr(ADDR_MODE[ch], 8'h03);
      wr(ADDR_MODE[ch], 8'h01);
      wr(ADDR_MODE[ch], 8'h41);
      n = ch ? 8'hFF : (8'($random(seed)) | 8'h01);
      wr(ADDR_CMP[ch], n);
      for (int pol = 0; pol < 2; pol++) begin
        wr(ADDR_MODE[ch], pol ? 8'hC3 : 8'hC1);
        wait_clk(600);
        hi = 0;
        repeat (512) begin
          @(posedge i_clk);
          #1;
          hi += o_port_out[ch];
        end
        chk("pwm high time", 16'(hi), 16'(pol ? 512 - 2 * n : 2 * n));
      end
      wr(ADDR_MODE[ch], 8'h43);
      wait_clk(3);
      chk("pwm stopped", 16'(o_port_out[ch]), 16'h0001);
      wr(ADDR_MODE[ch], 8'h41);
      wait_clk(3);
      chk("pwm level", 16'(o_port_out[ch]), 16'h0000);
      wr(ADDR_MODE[ch], 8'h40);
      wr(ADDR_MODE[ch], 8'h00);
    end
    $display("output test done");
    end_of_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    error_cnt++;
    end_of_test;
  end
endmodule
